// *** src/seg_xlate_pkg.sv ***
// Constants and types shared by the address translation block
package seg_xlate_pkg;
	localparam int LIN_W          = 32;
	localparam int PHYS_W         = 24;
	localparam int SEL_W          = 16;
	localparam int SEL_SHIFT      = 4;
	localparam int REAL_W         = 20;
	localparam int CTRL_PE_POS    = 0;
	localparam int CTRL_PG_POS    = 31;
	localparam int PAGE_OFS_W     = 12;
	localparam int QUEUE_DEPTH    = 16;
	localparam int MAX_OPERANDS   = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		SEG_ES,
		SEG_CS,
		SEG_SS,
		SEG_DS,
		SEG_FS,
		SEG_GS
	} seg_t;

	typedef enum logic [1:0] {
		ACC_DATA,
		ACC_STACK,
		ACC_FETCH,
		ACC_STRDST
	} acc_t;

	typedef enum logic [1:0] {
		OPD_NONE,
		OPD_REG,
		OPD_IMM,
		OPD_MEM
	} opd_src_t;

	typedef enum logic [1:0] {
		SZ_8,
		SZ_16,
		SZ_32
	} opsize_t;
endpackage

// *** src/fetch_queue_if.sv ***
// Interface carrying instruction bytes between the queue and the decoder
`timescale 1ns/1ps
`default_nettype none
interface fetch_queue_if;
	logic       push;
	logic [7:0] push_byte;
	logic       full;
	logic       pop;
	logic [7:0] head_byte;
	logic       head_valid;
	logic       flush;
	modport queue (
		input  push, push_byte, pop, flush,
		output full, head_byte, head_valid
	);
	modport user (
		output push, push_byte, pop, flush,
		input  full, head_byte, head_valid
	);
endinterface
`default_nettype wire

// *** src/prefetch_queue.sv ***
// Prefetch byte queue ahead of decode, registered head byte
`timescale 1ns/1ps
`default_nettype none
module prefetch_queue
	import seg_xlate_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	input  wire logic   clk_in,
	input  wire logic   reset_in,
	input  wire logic   enable_in,
	fetch_queue_if.queue q
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0]  mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   count_reg;
	logic [7:0]  head_reg;
	logic        do_push;
	logic        do_pop;
	logic        empty;

	assign empty = (count_reg == '0);
	assign q.full = (count_reg == (AW+1)'(DEPTH));
	assign do_push = q.push && !q.full;
	assign do_pop = q.pop && !empty;
	assign q.head_valid = !empty;
	assign q.head_byte = head_reg;

	always_ff @(posedge clk_in) begin
		if (enable_in && do_push) begin
			mem_reg[wr_reg] <= q.push_byte;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
		end else if (enable_in) begin
			if (q.flush) begin
				wr_reg <= '0;
				rd_reg <= '0;
				count_reg <= '0;
			end else begin
				if (do_push) begin
					wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
				end
				if (do_pop) begin
					rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
				end
				count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
			end
		end
	end

	// Head loaded on the same edge as the pointers; decoder reads it with head_valid
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			head_reg <= 8'h00;
		end else if (enable_in) begin
			// Head must not move on a push behind an existing head
			if (do_pop) begin
				if (count_reg == (AW+1)'(1)) begin
					head_reg <= q.push_byte;
				end else begin
					head_reg <= mem_reg[rd_reg == AW'(DEPTH - 1) ? '0
						: rd_reg + 1'b1];
				end
			end else if (count_reg == '0) begin
				head_reg <= q.push_byte;
			end
		end
	end
endmodule
`default_nettype wire

// *** src/seg_xlate.sv ***
// Logical to linear to physical address translation with fetch queue
// Functional notes
// - Up to sixteen prefetched instruction bytes wait in a queue before decode.
// - Up to three operands, each from register, immediate, or memory.
// - Default operand widths: 8 or 32 in protected 32-bit code, 8 or 16 otherwise.
// - Length prefix inverts default wide operand width.
// - Multi-byte values stored low byte first at ascending locations.
// - A multi-byte value is addressed by its lowest byte.
// - Paging works on fixed 4K byte pages.
// - Offset sums supplied base, index and displacement; pairs with selector.
// - Unprotected mode: selector shifted left four plus offset.
// - Protected mode: 32-bit segment base plus offset.
// - Protected with paging: full linear address goes to paging unit.
// - Default segments: data uses data, stack uses stack, fetch uses code.
// - Fetch offset is the instruction pointer.
// - Override prefix replaces data default; only way to reach second and third extra segments.
// - Any segment bases accepted, no overlap check.
// - Segment size from one byte to four gigabytes.
// - Protection-enable bit 0 selects protected translation.
// - Paging-enable bit 31 routes linear addresses to paging unit when protection-enable bit 0 is also set.
`timescale 1ns/1ps
`default_nettype none
module seg_xlate
	import seg_xlate_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              enable_in,
	// Mode control word
	input  wire logic [31:0]       ctrl_word_in,
	input  wire logic              code_32_in,
	// Segment selectors and bases
	input  wire logic [SEL_W-1:0]  extra_segment_sel_in,
	input  wire logic [SEL_W-1:0]  code_segment_sel_in,
	input  wire logic [SEL_W-1:0]  stack_segment_sel_in,
	input  wire logic [SEL_W-1:0]  data_segment_sel_in,
	input  wire logic [SEL_W-1:0]  second_extra_segment_sel_in,
	input  wire logic [SEL_W-1:0]  third_extra_segment_sel_in,
	input  wire logic [6*LIN_W-1:0] seg_bases_in,
	// Translation request
	input  wire logic              req_valid_in,
	input  wire logic [1:0]        req_access_in,
	input  wire logic              req_override_in,
	input  wire logic [2:0]        req_override_seg_in,
	input  wire logic [LIN_W-1:0]  req_ip_in,
	input  wire logic              req_use_base_in,
	input  wire logic [LIN_W-1:0]  req_base_in,
	input  wire logic              req_use_index_in,
	input  wire logic [LIN_W-1:0]  req_index_in,
	input  wire logic [1:0]        req_scale_in,
	input  wire logic [LIN_W-1:0]  req_disp_in,
	// Operand description
	input  wire logic [1:0]        opd_count_in,
	input  wire logic [5:0]        opd_src_in,
	input  wire logic              opd_byte_in,
	input  wire logic              opd_len_prefix_in,
	// Fetch queue
	input  wire logic              fetch_push_in,
	input  wire logic [7:0]        fetch_byte_in,
	input  wire logic              fetch_flush_in,
	input  wire logic              decode_pop_in,
	// Store data for byte lanes
	input  wire logic [31:0]       store_data_in,
	// Outputs
	output logic                   xlate_valid_out,
	output logic [LIN_W-1:0]       linear_addr_out,
	output logic [PHYS_W-1:0]      phys_addr_out,
	output logic                   to_paging_out,
	output logic [19:0]            page_number_out,
	output logic [PAGE_OFS_W-1:0]  page_offset_out,
	output logic [1:0]             opsize_out,
	output logic                   opd_ok_out,
	output logic [31:0]            store_bytes_out,
	output logic                   fetch_full_out,
	output logic [7:0]             decode_byte_out,
	output logic                   decode_valid_out
);
	fetch_queue_if fq ();

	logic              prot_mode;
	logic              paging_on;
	seg_t              seg_sel;
	logic [LIN_W-1:0]  seg_base;
	logic [SEL_W-1:0]  selector;
	logic [LIN_W-1:0]  eff_ofs;
	logic [LIN_W-1:0]  lin_next;
	opsize_t           opsize_next;
	logic              opd_ok_next;

	logic              xlate_valid_reg;
	logic [LIN_W-1:0]  linear_reg;
	logic [PHYS_W-1:0] phys_reg;
	logic              paging_reg;
	logic [1:0]        opsize_reg;
	logic              opd_ok_reg;
	logic [31:0]       store_reg;

	assign prot_mode = ctrl_word_in[CTRL_PE_POS];
	// Paging has no meaning without protection
	assign paging_on = prot_mode && ctrl_word_in[CTRL_PG_POS];

	assign fq.push = fetch_push_in;
	assign fq.push_byte = fetch_byte_in;
	assign fq.pop = decode_pop_in;
	assign fq.flush = fetch_flush_in;
	assign fetch_full_out = fq.full;
	assign decode_byte_out = fq.head_byte;
	assign decode_valid_out = fq.head_valid;

	prefetch_queue #(
		.DEPTH     (DEPTH)
	) u_queue (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.enable_in (enable_in),
		.q         (fq)
	);

	// Segment choice; fetch, stack and string destination ignore overrides
	always_comb begin
		unique case (acc_t'(req_access_in))
			ACC_FETCH: seg_sel = SEG_CS;
			ACC_STACK: seg_sel = SEG_SS;
			ACC_STRDST: seg_sel = SEG_ES;
			ACC_DATA: begin
				if (req_override_in && req_override_seg_in <= 3'(SEG_GS)) begin
					seg_sel = seg_t'(req_override_seg_in);
				end else begin
					seg_sel = SEG_DS;
				end
			end
		endcase
	end

	always_comb begin
		unique case (seg_sel)
			SEG_ES: selector = extra_segment_sel_in;
			SEG_CS: selector = code_segment_sel_in;
			SEG_SS: selector = stack_segment_sel_in;
			SEG_DS: selector = data_segment_sel_in;
			SEG_FS: selector = second_extra_segment_sel_in;
			SEG_GS: selector = third_extra_segment_sel_in;
			default: selector = data_segment_sel_in;
		endcase
	end

	// Any base mix is legal; no overlap check
	assign seg_base = seg_bases_in[32'(seg_sel) * LIN_W +: LIN_W];

	// Offset wraps at 32 bits, so segments span up to four gigabytes
	always_comb begin
		if (acc_t'(req_access_in) == ACC_FETCH) begin
			eff_ofs = req_ip_in;
		end else begin
			eff_ofs = req_disp_in
				+ (req_use_base_in ? req_base_in : '0)
				+ (req_use_index_in ? (req_index_in << req_scale_in) : '0);
		end
	end

	always_comb begin
		if (prot_mode) begin
			lin_next = seg_base + eff_ofs;
		end else begin
			lin_next = {12'h000, REAL_W'({selector, 4'h0}
				+ {4'h0, eff_ofs[SEL_W-1:0]})};
		end
	end

	// 16-bit default in unprotected mode or 16-bit code
	always_comb begin
		if (opd_byte_in) begin
			opsize_next = SZ_8;
		end else if ((code_32_in && prot_mode) ^ opd_len_prefix_in) begin
			opsize_next = SZ_32;
		end else begin
			opsize_next = SZ_16;
		end
	end

	// Count fits the limit; every used slot names a real source
	always_comb begin
		opd_ok_next = (32'(opd_count_in) <= MAX_OPERANDS);
		for (int i = 0; i < MAX_OPERANDS; i++) begin
			if (i < 32'(opd_count_in) && opd_src_t'(opd_src_in[2*i +: 2]) == OPD_NONE) begin
				opd_ok_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			xlate_valid_reg <= 1'b0;
			linear_reg <= 32'h0000_0000;
			phys_reg <= 24'h00_0000;
			paging_reg <= 1'b0;
		end else if (enable_in) begin
			xlate_valid_reg <= req_valid_in;
			if (req_valid_in) begin
				linear_reg <= lin_next;
				phys_reg <= lin_next[PHYS_W-1:0];
				paging_reg <= paging_on;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			opsize_reg <= 2'h0;
			opd_ok_reg <= 1'b0;
			store_reg <= 32'h0000_0000;
		end else if (enable_in && req_valid_in) begin
			opsize_reg <= 2'(opsize_next);
			opd_ok_reg <= opd_ok_next;
			// Lane 0 is the lowest address, least significant byte first
			store_reg <= {store_data_in[31:24], store_data_in[23:16],
				store_data_in[15:8], store_data_in[7:0]};
		end
	end

	assign xlate_valid_out = xlate_valid_reg;
	assign linear_addr_out = linear_reg;
	assign to_paging_out = paging_reg;
	// Physical bus shows truncated linear only when paging is bypassed
	assign phys_addr_out = paging_reg ? 24'h00_0000 : phys_reg;
	assign page_number_out = linear_reg[LIN_W-1:PAGE_OFS_W];
	assign page_offset_out = linear_reg[PAGE_OFS_W-1:0];
	assign opsize_out = opsize_reg;
	assign opd_ok_out = opd_ok_reg;
	assign store_bytes_out = store_reg;
endmodule
`default_nettype wire

// *** tb/page_unit_model.sv ***
// Behavioural paging unit standing beyond the translation block
`timescale 1ns/1ps
`default_nettype none
module page_unit_model #(
	parameter logic [11:0] FRAME_XOR = 12'h5A3
) (
	// Split linear address from the block
	input  wire logic        to_paging_in,
	input  wire logic [19:0] page_number_in,
	input  wire logic [11:0] page_offset_in,
	// Physical address it would put on the pins
	output logic [23:0]      phys_out
);
	// Fixed frame scramble stands in for page tables
	always_comb begin
		phys_out = {page_number_in[11:0] ^ FRAME_XOR, page_offset_in};
		// Not routed here: show junk, never a stale match
		if (!to_paging_in) begin
			phys_out = ~phys_out;
		end
	end
endmodule
`default_nettype wire

// *** tb/seg_xlate_asserts.sv ***
// Port checks for the address translation block
`timescale 1ns/1ps
`default_nettype none
module seg_xlate_asserts (
	input wire logic        clk_in, reset_in, enable_in, req_valid_in,
	input wire logic        opd_byte_in, xlate_valid_out, to_paging_out,
	input wire logic        fetch_full_out, decode_pop_in, fetch_flush_in,
	input wire logic [1:0]  req_access_in, opsize_out,
	input wire logic [31:0] ctrl_word_in, store_data_in, req_ip_in,
	input wire logic [15:0] code_segment_sel_in,
	input wire logic [31:0] linear_addr_out, store_bytes_out,
	input wire logic [23:0] phys_addr_out,
	input wire logic [19:0] page_number_out,
	input wire logic [11:0] page_offset_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_take;
		enable_in && req_valid_in;
	endsequence
	sequence s_real;
		s_take ##0 !ctrl_word_in[0];
	endsequence
	property p_answer;
		s_take |=> xlate_valid_out;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_cause;
		$past(enable_in) && xlate_valid_out |-> $past(req_valid_in);
	endproperty
	a_cause: assert property (p_cause) else $error("stray valid");
	property p_real;
		s_real |=> !to_paging_out && linear_addr_out[31:20] == 12'h000;
	endproperty
	a_real: assert property (p_real) else $error("real range");
	property p_fetch;
		s_real ##0 req_access_in == 2'h2 |=> linear_addr_out ==
			((({16'h0, $past(code_segment_sel_in)} << 4) +
			($past(req_ip_in) & 32'h0000_FFFF)) & 32'h000F_FFFF);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch addr");
	property p_paged;
		s_take ##0 ctrl_word_in[0] && ctrl_word_in[31]
			|=> to_paging_out && phys_addr_out == 24'h0;
	endproperty
	a_paged: assert property (p_paged) else $error("no paging");
	property p_trunc;
		xlate_valid_out && !to_paging_out
			|-> phys_addr_out == linear_addr_out[23:0];
	endproperty
	a_trunc: assert property (p_trunc) else $error("phys trunc");
	property p_split;
		xlate_valid_out
			|-> {page_number_out, page_offset_out} == linear_addr_out;
	endproperty
	a_split: assert property (p_split) else $error("page split");
	property p_store;
		s_take |=> store_bytes_out == $past(store_data_in);
	endproperty
	a_store: assert property (p_store) else $error("byte order");
	property p_byte;
		s_take ##0 opd_byte_in |=> opsize_out == 2'h0;
	endproperty
	a_byte: assert property (p_byte) else $error("byte size");
	property p_full;
		fetch_full_out && enable_in && !decode_pop_in && !fetch_flush_in
			|=> fetch_full_out;
	endproperty
	a_full: assert property (p_full) else $error("full lost");
endmodule
bind seg_xlate seg_xlate_asserts chk_i (
	.clk_in, .reset_in, .enable_in, .req_valid_in, .opd_byte_in,
	.xlate_valid_out, .to_paging_out, .fetch_full_out, .decode_pop_in,
	.fetch_flush_in, .req_access_in, .opsize_out, .ctrl_word_in,
	.store_data_in, .req_ip_in, .code_segment_sel_in, .linear_addr_out,
	.store_bytes_out, .phys_addr_out, .page_number_out, .page_offset_out
);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the address translation block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import seg_xlate_pkg::*;
	logic               clk_in, reset_in, enable_in, code_32_in;
	logic               req_valid_in, req_override_in, req_use_base_in;
	logic               req_use_index_in, opd_byte_in, opd_len_prefix_in;
	logic               fetch_push_in, fetch_flush_in, decode_pop_in;
	logic [31:0]        ctrl_word_in, req_ip_in, req_base_in, req_index_in;
	logic [31:0]        req_disp_in, store_data_in, rnd, v;
	logic [SEL_W-1:0]   sel [6];
	logic [6*LIN_W-1:0] seg_bases_in;
	logic [1:0]         req_access_in, req_scale_in, opd_count_in;
	logic [2:0]         req_override_seg_in;
	logic [5:0]         opd_src_in;
	logic [7:0]         fetch_byte_in, decode_byte_out;
	logic               xlate_valid_out, to_paging_out, opd_ok_out;
	logic               fetch_full_out, decode_valid_out;
	logic [31:0]        linear_addr_out, store_bytes_out;
	logic [23:0]        phys_addr_out, paged_addr;
	logic [19:0]        page_number_out;
	logic [11:0]        page_offset_out;
	logic [1:0]         opsize_out;
	int                 fails, n_tests;
	logic [7:0]         q[$];
	seg_xlate dut (
		.clk_in, .reset_in, .enable_in, .ctrl_word_in, .code_32_in,
		.extra_segment_sel_in(sel[0]), .code_segment_sel_in(sel[1]),
		.stack_segment_sel_in(sel[2]), .data_segment_sel_in(sel[3]),
		.second_extra_segment_sel_in(sel[4]),
		.third_extra_segment_sel_in(sel[5]), .seg_bases_in, .req_valid_in,
		.req_access_in, .req_override_in, .req_override_seg_in, .req_ip_in,
		.req_use_base_in, .req_base_in, .req_use_index_in, .req_index_in,
		.req_scale_in, .req_disp_in, .opd_count_in, .opd_src_in,
		.opd_byte_in, .opd_len_prefix_in, .fetch_push_in, .fetch_byte_in,
		.fetch_flush_in, .decode_pop_in, .store_data_in, .xlate_valid_out,
		.linear_addr_out, .phys_addr_out, .to_paging_out, .page_number_out,
		.page_offset_out, .opsize_out, .opd_ok_out, .store_bytes_out,
		.fetch_full_out, .decode_byte_out, .decode_valid_out
	);
	page_unit_model pager (
		.to_paging_in(to_paging_out), .page_number_in(page_number_out),
		.page_offset_in(page_offset_out), .phys_out(paged_addr)
	);
	function automatic logic [31:0] r();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (!ok) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Index i sweeps every access kind and override code, back to back
	task automatic xlate(input int i);
		logic [31:0] off, lin;
		logic        pe, tp, ok;
		int          k;
		v = r();
		ctrl_word_in = v;
		{code_32_in, opd_byte_in, opd_len_prefix_in} = {v[5], v[7], v[9]};
		{req_use_base_in, req_use_index_in} = {v[11], v[13]};
		{req_scale_in, opd_count_in, opd_src_in} = v[25:14];
		req_access_in = 2'(i % 4);
		req_override_seg_in = 3'((i / 4) % 8);
		req_override_in = 1'((i / 32) % 2);
		{req_ip_in, req_base_in, req_index_in} = {r(), r(), r()};
		{req_disp_in, store_data_in} = {r(), r()};
		for (k = 0; k < 6; k++) begin
			sel[k] = SEL_W'(r());
			seg_bases_in[32*k+:32] = (i >= 56) ? 32'h0 : r();
		end
		req_valid_in = 1'b1;
		k = req_access_in == 2'h2 ? 1 : req_access_in == 2'h1 ? 2 :
			req_access_in == 2'h3 ? 0 :
			(req_override_in && req_override_seg_in < 6) ?
			req_override_seg_in : 3;
		off = req_access_in == 2'h2 ? req_ip_in :
			(req_use_base_in ? req_base_in : 32'h0) + req_disp_in +
			(req_use_index_in ? req_index_in << req_scale_in : 32'h0);
		ok = 1'b1;
		for (int j = 0; j < 3; j++) begin
			if (j < opd_count_in && opd_src_in[2*j+:2] == 2'h0) begin
				ok = 1'b0;
			end
		end
		pe = ctrl_word_in[0];
		tp = pe & ctrl_word_in[31];
		lin = pe ? seg_bases_in[32*k+:32] + off :
			(({16'h0, sel[k]} << 4) + off[15:0]) & 32'h000F_FFFF;
		@(negedge clk_in);
		chk(xlate_valid_out === 1'b1, "no result");
		chk(linear_addr_out === lin, "linear");
		chk(to_paging_out === tp, "route");
		chk(phys_addr_out === (tp ? 24'h0 : lin[23:0]), "phys");
		chk(!tp || paged_addr === {lin[23:12] ^ 12'h5A3, lin[11:0]},
			"paged");
		chk(opsize_out === (opd_byte_in ? 2'h0 : ((pe & code_32_in) ^
			opd_len_prefix_in) ? 2'h2 : 2'h1), "size");
		chk(store_bytes_out === store_data_in, "lanes");
		chk(opd_ok_out === ok, "operands");
	endtask
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	initial begin
		rnd = 32'hD56E;
		{fails, n_tests} = '0;
		{reset_in, enable_in} = 2'b11;
		{code_32_in, req_valid_in, req_override_in, req_use_base_in,
			req_use_index_in, opd_byte_in, opd_len_prefix_in} = '0;
		{fetch_push_in, fetch_flush_in, decode_pop_in} = '0;
		{ctrl_word_in, req_ip_in, req_base_in, req_index_in} = '0;
		{req_disp_in, store_data_in, seg_bases_in} = '0;
		{req_access_in, req_scale_in, opd_count_in} = '0;
		{req_override_seg_in, opd_src_in, fetch_byte_in} = '0;
		sel = '{default: '0};
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		for (int i = 0; i < 64; i++) xlate(i);
		// Frozen block must ignore a request
		v = linear_addr_out;
		enable_in = 1'b0;
		req_disp_in = r();
		@(negedge clk_in);
		chk(linear_addr_out === v, "freeze");
		{req_valid_in, enable_in} = 2'b01;
		$display("translate test done");
		// Seventeenth byte must be refused
		for (int i = 0; i < 17; i++) begin
			v = r();
			{fetch_push_in, fetch_byte_in} = {1'b1, v[7:0]};
			if (i < 16) q.push_back(v[7:0]);
			@(negedge clk_in);
		end
		fetch_push_in = 1'b0;
		chk(fetch_full_out === 1'b1, "full");
		foreach (q[i]) begin
			@(negedge clk_in);
			chk(decode_valid_out === 1'b1 && decode_byte_out === q[i],
				"head");
			decode_pop_in = 1'b1;
			@(negedge clk_in);
			decode_pop_in = 1'b0;
		end
		@(negedge clk_in);
		chk(decode_valid_out === 1'b0, "empty");
		fetch_push_in = 1'b1;
		@(negedge clk_in);
		{fetch_push_in, fetch_flush_in} = 2'b01;
		@(negedge clk_in);
		fetch_flush_in = 1'b0;
		@(negedge clk_in);
		chk(decode_valid_out === 1'b0, "flush");
		$display("queue test done");
		close_out();
	end
endmodule
`default_nettype wire
